// [dv/atx_src_model.sv]
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// Serial audio source: 32 bit clocks per word, MSB first
// ----------------------------------------------------------------
module atx_src_model (
  // Clock
  input  wire logic clock_in,
  // Serial audio
  output logic      sck_out,
  output logic      frame_sync_out,
  output logic      sdata_out,
  output logic      user_out,
  output logic      validity_out
);
  logic [6:0]  cnt_ff = 7'h00;
  logic [23:0] word;

  // Frame sync counted from the master clock, fixed phase
  always @(negedge clock_in) begin
    cnt_ff <= cnt_ff + 7'h01;
  end

  assign sck_out        = cnt_ff[0];
  assign frame_sync_out = ~cnt_ff[6];
  assign word           = cnt_ff[6] ? 24'h3c5a0f : 24'ha5c3f0;
  // MSB ready at the first rise; past bit 24 the line keeps moving
  assign sdata_out      = (cnt_ff[5:1] < 5'h18) ? word[5'h17 - cnt_ff[5:1]] : cnt_ff[1];
  assign user_out       = cnt_ff[6];
  assign validity_out   = 1'b0;
endmodule // atx_src_model

`default_nettype wire

// [dv/atx_tx_pins_tb.sv]
`timescale 1ns/10ps
`default_nettype none

module atx_tx_pins_tb;
  import atx_pkg::*;

  logic clock_in   = 1'b0;
  logic sys_rst_in = 1'b1;
  logic fmt_n      = 1'b0;
  logic b62_n      = 1'b0;
  logic b1_rc0     = 1'b0;
  logic pt_rc1     = 1'b0;
  logic subcode_frame_clock        = 1'b0;
  logic sck, fs, sd, usr, vld, mk_out, mk_oe, pos, neg, cd, trn, sync;
  wire  mk_wire    = mk_oe ? mk_out : 1'b0;
  logic ln [0:4095];
  int   mismatches = 0;
  int   num_checks = 0;
  int   n;

  initial begin
    forever #12.5 clock_in = ~clock_in;
  end

  atx_src_model i_src (.clock_in(clock_in), .sck_out(sck), .frame_sync_out(fs),
    .sdata_out(sd), .user_out(usr), .validity_out(vld));

  atx_tx_pins i_dut (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .sck_in(sck),
    .frame_sync_in(fs), .sdata_in(sd), .user_in(usr), .validity_in(vld),
    .broadcast_format_select_n_in(fmt_n), .status_bit6_or_bit2_n_in(b62_n),
    .status_bit1_or_rate_code0_in(b1_rc0), .passthrough_or_rate_code1_in(pt_rc1),
    .status_in_or_subcode_frame_in(subcode_frame_clock), .block_marker_or_subcode_bitclk_in(mk_wire),
    .block_marker_or_subcode_bitclk_out(mk_out),
    .block_marker_or_subcode_bitclk_oe_out(mk_oe), .line_out_pos_out(pos),
    .line_out_neg_out(neg), .cd_mode_out(cd), .transparent_out(trn), .in_sync_out(sync));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Captures the line over one marker-high span; cell 0 of frame 0 A is sample 0
  task automatic read_block(output int hi);
    int t;
    t  = 0;
    hi = 0;
    while (mk_out !== 1'b0 && t < 30000) begin
      @(negedge clock_in);
      t++;
    end
    while (mk_out !== 1'b1 && t < 60000) begin
      @(negedge clock_in);
      t++;
    end
    while (mk_out === 1'b1 && hi < 20000) begin
      if (hi < 4096) ln[hi] = pos;
      hi++;
      @(negedge clock_in);
    end
  endtask

  // Biphase mark: a one has a mid-slot transition; slot 30 holds the status bit
  task automatic chk_cs(input logic [7:0] idx, input logic e);
    int b;
    b = int'(idx) * 128 + 60;
    chk("cs_chan_a", 16'(e), 16'(ln[b] ^ ln[b + 1]));
    chk("cs_chan_b", 16'(e), 16'(ln[b + 64] ^ ln[b + 65]));
  endtask

  task automatic count_marker(output int hi);
    hi = 0;
    repeat (256) begin
      @(negedge clock_in);
      if (mk_out === 1'b1) hi++;
    end
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(negedge clock_in);
    chk("line_rst", 16'h0000, 16'({pos, neg}));
    sys_rst_in = 1'b0;
    n = 0;
    while (sync !== 1'b1 && n < 2000) begin
      @(negedge clock_in);
      n++;
    end
    chk("in_sync", 16'h0001, 16'(sync));
    read_block(n);
    chk("marker_len", 16'h4000, 16'(n));
    chk("line_pair", 16'h0001, 16'(pos ^ neg));
    chk_cs(CS_FORMAT, 1'b1);
    chk_cs(CS_BIT1, 1'b1);
    chk_cs(CS_BIT6, 1'b1);
    fmt_n  = 1'b1;
    b62_n  = 1'b1;
    pt_rc1 = 1'b1;
    read_block(n);
    chk_cs(CS_FORMAT, 1'b0);
    chk_cs(CS_BIT2, 1'b0);
    chk_cs(CS_BIT24, 1'b1);
    chk_cs(CS_BIT25, 1'b1);
    chk("cd_off", 16'h0000, 16'(cd));
    b62_n  = 1'b0;
    b1_rc0 = 1'b1;
    pt_rc1 = 1'b0;
    read_block(n);
    chk_cs(CS_BIT2, 1'b1);
    chk_cs(CS_BIT24, 1'b0);
    chk_cs(CS_BIT25, 1'b1);
    // Subcode bit clock: strobe of two clocks per 64-clock word, gated by frame
    pt_rc1 = 1'b1;
    subcode_frame_clock    = 1'b1;
    repeat (8) @(negedge clock_in);
    chk("cd_on", 16'h0001, 16'(cd));
    count_marker(n);
    chk("sbc_gated", 16'h0000, 16'(n));
    subcode_frame_clock = 1'b0;
    repeat (8) @(negedge clock_in);
    count_marker(n);
    chk("sbc_run", 16'h0008, 16'(n));
    fmt_n = 1'b0;
    repeat (8) @(negedge clock_in);
    chk("transp", 16'h0001, 16'(trn));
    chk("marker_oe", 16'h0000, 16'(mk_oe));
    b62_n  = 1'b1;
    b1_rc0 = 1'b0;
    repeat (8) @(negedge clock_in);
    chk("transp_pins", 16'h0002, 16'({trn, cd}));
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clock_in);
    chk("line_rst2", 16'h0000, 16'({pos, neg, sync}));
    finish_test();
  end

  initial begin
    // Three marker spans take about 91k clocks; stay under 100k
    repeat (99000) @(posedge clock_in);
    mismatches++;
    finish_test();
  end
endmodule // atx_tx_pins_tb

`default_nettype wire

// [verilog/atx_pkg.sv]
// Functional notes
// - Consumer select high sends status bit 0 zero
// - Shared pin inverted drives bit 6 or 2
// - Professional bit 1 is inverse of pin
// - Consumer rate pins set status bits 24, 25
// - Rate codes: 44.1, 48, 32, 44.1 CD
// - Both rate pins high enter CD submode
// - Transparent mode ignores status pins except the serial status input
// - Passthrough pin selects transparent, marker becomes input
// - Shared input is status data or subcode frame
// - Marker high first 16 bytes, else subcode clock
// - Reset holds both line outputs low
// - All timing from one 128 Fs timebase
// - After reset align so A carries left
// - Strobe moves shift stage to holding, latches C/U/V
// - Input strobe on first edge, one bit period
// - Subcode bit clock is strobe gated by frame
// - After preamble, output strobe loads transmit stage
// - Strobe overlap forces internal realignment

package atx_pkg;

  // ----------------------------------------------------------------
  // Serial input
  // ----------------------------------------------------------------
  localparam int unsigned AUDIO_BITS    = 24;
  localparam logic [4:0]  AUDIO_BITS_C  = 5'h18;
  localparam logic [4:0]  BIT_CNT_ONE   = 5'h01;

  // ----------------------------------------------------------------
  // Subframe timebase, two cells per slot, 64 cells per subframe
  // ----------------------------------------------------------------
  localparam logic [5:0]  CELL_FIRST    = 6'h00;
  localparam logic [5:0]  CELL_LAST     = 6'h3f;
  localparam logic [5:0]  CELL_LDS      = 6'h07;
  localparam logic [4:0]  SLOT_DATA0    = 5'h04;
  localparam int unsigned POS_AUDIO     = 4;
  localparam int unsigned POS_V         = 28;
  localparam int unsigned POS_U         = 29;
  localparam int unsigned POS_C         = 30;
  localparam int unsigned POS_P         = 31;
  localparam logic [7:0]  PRE_BLOCK     = 8'he8;
  localparam logic [7:0]  PRE_CHAN_A    = 8'he2;
  localparam logic [7:0]  PRE_CHAN_B    = 8'he4;

  // ----------------------------------------------------------------
  // Channel status block
  // ----------------------------------------------------------------
  localparam logic [7:0]  FRAME_FIRST   = 8'h00;
  localparam logic [7:0]  FRAME_LAST    = 8'hbf;
  localparam logic [7:0]  MARKER_FRAMES = 8'h80;
  localparam logic [7:0]  CS_FORMAT     = 8'h00;
  localparam logic [7:0]  CS_BIT1       = 8'h01;
  localparam logic [7:0]  CS_BIT2       = 8'h02;
  localparam logic [7:0]  CS_BIT6       = 8'h06;
  localparam logic [7:0]  CS_BIT24      = 8'h18;
  localparam logic [7:0]  CS_BIT25      = 8'h19;
  localparam logic [1:0]  RATE_44K1     = 2'h0;
  localparam logic [1:0]  RATE_48K      = 2'h1;
  localparam logic [1:0]  RATE_32K      = 2'h2;
  localparam logic [1:0]  RATE_CD       = 2'h3;

  typedef struct packed {
    logic c;
    logic u;
    logic v;
  } atx_cuv_t;

  typedef struct packed {
    logic                  left;
    atx_cuv_t              cuv;
    logic [AUDIO_BITS-1:0] audio;
  } atx_word_t;

  typedef enum logic [1:0] {
    ST_ALIGN = 2'b01,
    ST_RUN   = 2'b10
  } atx_state_t;

  // Rate code to {bit24, bit25}
  function automatic logic [1:0] atx_rate_bits(input logic [1:0] code);
    case (code)
      RATE_48K: atx_rate_bits = 2'b01;
      RATE_32K: atx_rate_bits = 2'b11;
      default:  atx_rate_bits = 2'b00;
    endcase
  endfunction

endpackage

// [verilog/atx_serial_in.sv]
`timescale 1ns/10ps
`default_nettype none

module atx_serial_in (
  // Clock and reset
  input  wire logic              clock_in,
  input  wire logic              sys_rst_in,
  // Serial audio
  input  wire logic              sck_in,
  input  wire logic              frame_sync_in,
  input  wire logic              sdata_in,
  input  wire atx_pkg::atx_cuv_t cuv_in,
  // To transmitter
  output logic                   pld_out,
  output logic                   pld_rise_out,
  output atx_pkg::atx_word_t     hold_out
);
  import atx_pkg::*;

  logic                  sck_prev_ff;
  logic                  fs_prev_ff;
  logic                  armed_ff;
  logic                  arm_left_ff;
  logic                  cur_left_ff;
  logic                  pld_ff;
  logic                  pld_rise_ff;
  logic [4:0]            bit_cnt_ff;
  logic [AUDIO_BITS-1:0] shift_ff;
  atx_word_t             hold_ff;

  wire logic sck_rise  = sck_in & ~sck_prev_ff;
  wire logic fs_edge   = frame_sync_in ^ fs_prev_ff;
  // First bit edge after a frame sync change, same-cycle edge included
  wire logic load      = sck_rise & (armed_ff | fs_edge);
  wire logic nxt_armed = (armed_ff | fs_edge) & ~sck_rise;
  wire logic nxt_left  = fs_edge ? frame_sync_in : arm_left_ff;
  wire logic shifting  = sck_rise & ~load & (bit_cnt_ff < AUDIO_BITS_C);

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      sck_prev_ff <= 1'b0;
      fs_prev_ff  <= 1'b0;
      armed_ff    <= 1'b0;
      arm_left_ff <= 1'b0;
      pld_rise_ff <= 1'b0;
    end else begin
      sck_prev_ff <= sck_in;
      fs_prev_ff  <= frame_sync_in;
      armed_ff    <= nxt_armed;
      arm_left_ff <= nxt_left;
      pld_rise_ff <= load;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      pld_ff <= 1'b0;
    end else if (load) begin
      pld_ff <= 1'b1;
    end else if (sck_rise) begin
      pld_ff <= 1'b0;
    end
  end

  // Parallel transfer and C/U/V latch on the same strobe edge
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      shift_ff    <= '0;
      bit_cnt_ff  <= '0;
      hold_ff     <= '0;
      cur_left_ff <= 1'b0;
    end else if (load) begin
      hold_ff     <= '{left: cur_left_ff, cuv: cuv_in, audio: shift_ff};
      shift_ff    <= {{(AUDIO_BITS-1){1'b0}}, sdata_in};
      bit_cnt_ff  <= BIT_CNT_ONE;
      cur_left_ff <= nxt_left;
    end else if (shifting) begin
      shift_ff    <= {shift_ff[AUDIO_BITS-2:0], sdata_in};
      bit_cnt_ff  <= bit_cnt_ff + BIT_CNT_ONE;
    end
  end

  assign pld_out      = pld_ff;
  assign pld_rise_out = pld_rise_ff;
  assign hold_out     = hold_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_load_moves_word;
    @(posedge clock_in) disable iff (sys_rst_in)
      load |=> hold_ff.audio == $past(shift_ff) && pld_rise_ff;
  endproperty
  a_load_moves_word: assert property (p_load_moves_word)
    else $error("holding stage did not take shift stage");

  property p_pld_one_period;
    @(posedge clock_in) disable iff (sys_rst_in)
      sck_rise && pld_ff && !load |=> !pld_ff;
  endproperty
  a_pld_one_period: assert property (p_pld_one_period)
    else $error("input strobe outlived one bit period");

  property p_pld_rises;
    @(posedge clock_in) disable iff (sys_rst_in)
      load |=> pld_ff ##1 (pld_ff || sck_prev_ff);
  endproperty
  a_pld_rises: assert property (p_pld_rises)
    else $error("input strobe missing after first edge");

endmodule // atx_serial_in

`default_nettype wire

// [verilog/atx_tx_pins.sv]
`timescale 1ns/10ps
`default_nettype none

module atx_tx_pins (
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic sys_rst_in,
  // Serial audio source
  input  wire logic sck_in,
  input  wire logic frame_sync_in,
  input  wire logic sdata_in,
  input  wire logic user_in,
  input  wire logic validity_in,
  // Control pins
  input  wire logic broadcast_format_select_n_in,
  input  wire logic status_bit6_or_bit2_n_in,
  input  wire logic status_bit1_or_rate_code0_in,
  input  wire logic passthrough_or_rate_code1_in,
  input  wire logic status_in_or_subcode_frame_in,
  // Block marker / subcode bit clock pin
  input  wire logic block_marker_or_subcode_bitclk_in,
  output logic      block_marker_or_subcode_bitclk_out,
  output logic      block_marker_or_subcode_bitclk_oe_out,
  // Line driver
  output logic      line_out_pos_out,
  output logic      line_out_neg_out,
  // Status
  output logic      cd_mode_out,
  output logic      transparent_out,
  output logic      in_sync_out
);
  import atx_pkg::*;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire logic       consumer  = broadcast_format_select_n_in;
  wire logic       transp    = ~consumer & passthrough_or_rate_code1_in;
  wire logic [1:0] rate_code = {passthrough_or_rate_code1_in, status_bit1_or_rate_code0_in};
  wire logic       cd        = consumer & (rate_code == RATE_CD);
  wire logic [1:0] rate_bits = atx_rate_bits(rate_code);
  wire logic       subcode_frame_clock       = status_in_or_subcode_frame_in;

  // Shared input is status data except in CD submode
  wire atx_cuv_t   cuv_pins  = '{c: subcode_frame_clock & ~cd, u: user_in, v: validity_in};

  logic      input_load_strobe;
  logic      pld_rise;
  atx_word_t hold_word;

  atx_serial_in u_serial_in (
    .clock_in      (clock_in),
    .sys_rst_in    (sys_rst_in),
    .sck_in        (sck_in),
    .frame_sync_in (frame_sync_in),
    .sdata_in      (sdata_in),
    .cuv_in        (cuv_pins),
    .pld_out       (input_load_strobe),
    .pld_rise_out  (pld_rise),
    .hold_out      (hold_word)
  );

  // ----------------------------------------------------------------
  // Timebase
  // ----------------------------------------------------------------
  atx_state_t  state_ff;
  logic        half_ff;
  logic [5:0]  cell_ff;
  logic        chan_b_ff;
  logic [7:0]  frame_ff;
  logic        blk_prev_ff;
  logic        blk_seen_ff;

  // Transparent master clock runs at twice the rate, so halve it
  wire logic tick      = ~transp | half_ff;
  wire logic running   = (state_ff == ST_RUN);
  wire logic output_load_strobe       = running & tick & (cell_ff == CELL_LDS);
  wire logic overlap   = output_load_strobe & input_load_strobe;
  wire logic align_go  = (state_ff == ST_ALIGN) & pld_rise & hold_word.left;
  wire logic sub_end   = running & tick & (cell_ff == CELL_LAST);
  wire logic frame_end = sub_end & chan_b_ff;
  wire logic blk_rise  = block_marker_or_subcode_bitclk_in & ~blk_prev_ff;
  wire logic blk_take  = frame_end & blk_seen_ff;
  // Marker edge raised in the consuming cycle is kept
  wire logic nxt_seen  = transp & (blk_rise | (blk_seen_ff & ~blk_take));
  wire logic [7:0] nxt_frame = (blk_take || frame_ff == FRAME_LAST) ?
                               FRAME_FIRST : frame_ff + 8'h01;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_ff <= ST_ALIGN;
    end else begin
      case (state_ff)
        ST_ALIGN: if (align_go) state_ff <= ST_RUN;
        ST_RUN:   if (overlap) state_ff <= ST_ALIGN;
        default:  state_ff <= ST_ALIGN;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in || !running) begin
      half_ff     <= 1'b0;
      cell_ff     <= CELL_FIRST;
      chan_b_ff   <= 1'b0;
      frame_ff    <= FRAME_FIRST;
    end else if (tick) begin
      half_ff     <= ~half_ff;
      cell_ff     <= cell_ff + 6'h01;
      if (sub_end) chan_b_ff <= ~chan_b_ff;
      if (frame_end) frame_ff <= nxt_frame;
    end else begin
      half_ff     <= ~half_ff;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      blk_prev_ff <= 1'b0;
      blk_seen_ff <= 1'b0;
    end else begin
      blk_prev_ff <= block_marker_or_subcode_bitclk_in;
      blk_seen_ff <= nxt_seen;
    end
  end

  // ----------------------------------------------------------------
  // Channel status from pins
  // ----------------------------------------------------------------
  // Indexed by frame only, so A and B carry the same pin bits
  wire logic is_fmt   = (frame_ff == CS_FORMAT);
  wire logic is_b1    = (frame_ff == CS_BIT1);
  wire logic is_b2    = (frame_ff == CS_BIT2);
  wire logic is_b6    = (frame_ff == CS_BIT6);
  wire logic is_b24   = (frame_ff == CS_BIT24);
  wire logic is_b25   = (frame_ff == CS_BIT25);
  wire logic pro_cs   = is_fmt | (is_b1 & ~status_bit1_or_rate_code0_in)
                      | (is_b6 & ~status_bit6_or_bit2_n_in);
  wire logic con_cs   = (is_b2 & ~status_bit6_or_bit2_n_in)
                      | (is_b24 & rate_bits[1]) | (is_b25 & rate_bits[0]);
  wire logic pin_cs   = ~transp & (consumer ? con_cs : pro_cs);
  // Serial status input is ORed over the pin bits; no CRC byte is generated
  wire logic cs_bit   = pin_cs | hold_word.cuv.c;
  wire logic [31:0] load_word = {1'b0, cs_bit, hold_word.cuv.u, hold_word.cuv.v,
                                 hold_word.audio, 4'h0};
  wire logic parity   = ^load_word[POS_C:POS_AUDIO];

  // ----------------------------------------------------------------
  // Transmit stage and biphase-mark encoder
  // ----------------------------------------------------------------
  logic [31:0] tx_ff;
  logic        level_ff;
  logic        pre_inv_ff;

  wire logic [4:0] slot     = cell_ff[5:1];
  wire logic [7:0] pre_sel  = chan_b_ff ? PRE_CHAN_B :
                              (frame_ff == FRAME_FIRST ? PRE_BLOCK : PRE_CHAN_A);
  wire logic       inv_now  = (cell_ff == CELL_FIRST) ? level_ff : pre_inv_ff;
  wire logic       pre_cell = pre_sel[~cell_ff[2:0]] ^ inv_now;
  wire logic       data_lvl = cell_ff[0] ? level_ff ^ tx_ff[slot] : ~level_ff;
  wire logic       nxt_lvl  = (slot < SLOT_DATA0) ? pre_cell : data_lvl;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      tx_ff <= '0;
    end else if (output_load_strobe) begin
      tx_ff <= {parity, load_word[POS_C:0]};
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in || !running) begin
      level_ff   <= 1'b0;
      pre_inv_ff <= 1'b0;
    end else if (tick) begin
      level_ff   <= nxt_lvl;
      if (cell_ff == CELL_FIRST) pre_inv_ff <= level_ff;
    end
  end

  // ----------------------------------------------------------------
  // Output pins
  // ----------------------------------------------------------------
  wire logic marker_lvl = running & (frame_ff < MARKER_FRAMES);
  wire logic sbc_lvl    = input_load_strobe & ~subcode_frame_clock;
  wire logic nxt_blk    = cd ? sbc_lvl : marker_lvl;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      line_out_pos_out                      <= 1'b0;
      line_out_neg_out                      <= 1'b0;
      block_marker_or_subcode_bitclk_out    <= 1'b0;
      block_marker_or_subcode_bitclk_oe_out <= 1'b0;
      cd_mode_out                           <= 1'b0;
      transparent_out                       <= 1'b0;
      in_sync_out                           <= 1'b0;
    end else begin
      line_out_pos_out                      <= running & nxt_lvl;
      line_out_neg_out                      <= running & ~nxt_lvl;
      block_marker_or_subcode_bitclk_out    <= nxt_blk & ~transp;
      block_marker_or_subcode_bitclk_oe_out <= ~transp;
      cd_mode_out                           <= cd;
      transparent_out                       <= transp;
      in_sync_out                           <= running & ~overlap;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_align_start;
    (state_ff == ST_ALIGN) ##0 (pld_rise && hold_word.left);
  endsequence
  sequence s_run_from_a;
    running && cell_ff == CELL_FIRST && !chan_b_ff;
  endsequence

  property p_reset_lines_low;
    disable iff (1'b0) sys_rst_in |=> !line_out_pos_out && !line_out_neg_out;
  endproperty
  a_reset_lines_low: assert property (p_reset_lines_low)
    else $error("line outputs not low in reset");

  property p_align;
    s_align_start |=> s_run_from_a;
  endproperty
  a_align: assert property (p_align)
    else $error("timebase did not start on left word");

  property p_overlap_realign;
    overlap |=> state_ff == ST_ALIGN ##1 !line_out_pos_out && !line_out_neg_out;
  endproperty
  a_overlap_realign: assert property (p_overlap_realign)
    else $error("strobe overlap did not realign");

  property p_lds_load;
    output_load_strobe |=> tx_ff[POS_V+AUDIO_BITS-1-POS_V+POS_AUDIO:POS_AUDIO] == $past(hold_word.audio)
            && cell_ff == CELL_LDS + 6'h01;
  endproperty
  a_lds_load: assert property (p_lds_load)
    else $error("transmit stage not loaded after preamble");

  property p_consumer_fmt;
    output_load_strobe && consumer && is_fmt && !hold_word.cuv.c |=> !tx_ff[POS_C];
  endproperty
  a_consumer_fmt: assert property (p_consumer_fmt)
    else $error("consumer format bit not zero");

  property p_pro_bit1;
    output_load_strobe && !consumer && !transp && is_b1 && !status_bit1_or_rate_code0_in |=> tx_ff[POS_C];
  endproperty
  a_pro_bit1: assert property (p_pro_bit1)
    else $error("professional bit 1 not inverse of pin");

  property p_con_bit2;
    output_load_strobe && consumer && is_b2 && !status_bit6_or_bit2_n_in |=> tx_ff[POS_C];
  endproperty
  a_con_bit2: assert property (p_con_bit2)
    else $error("consumer bit 2 not inverse of pin");

  property p_rate_32;
    output_load_strobe && consumer && is_b24 && rate_code == RATE_32K |=> tx_ff[POS_C];
  endproperty
  a_rate_32: assert property (p_rate_32)
    else $error("rate code 32 kHz not sent in bit 24");

  property p_transp_ignore;
    output_load_strobe && transp && !hold_word.cuv.c |=> !tx_ff[POS_C];
  endproperty
  a_transp_ignore: assert property (p_transp_ignore)
    else $error("status pins used in transparent mode");

  property p_sbc_gate;
    cd && !transp |=> block_marker_or_subcode_bitclk_out == $past(sbc_lvl);
  endproperty
  a_sbc_gate: assert property (p_sbc_gate)
    else $error("subcode bit clock not gated strobe");

  property p_marker;
    !cd && !transp && running && frame_ff < MARKER_FRAMES |=> block_marker_or_subcode_bitclk_out;
  endproperty
  a_marker: assert property (p_marker)
    else $error("block marker low in first 16 bytes");

  property p_modes;
    (consumer && rate_code == RATE_CD |=> cd_mode_out) and
    (!consumer && passthrough_or_rate_code1_in |=> !block_marker_or_subcode_bitclk_oe_out);
  endproperty
  a_modes: assert property (p_modes)
    else $error("mode decode wrong");

  property p_timebase;
    running && !transp && !overlap |=> cell_ff == 6'($past(cell_ff) + 6'h01);
  endproperty
  a_timebase: assert property (p_timebase)
    else $error("timebase did not advance one cell");

endmodule // atx_tx_pins

`default_nettype wire
